// File: rtl/opt_loader_pkg.sv
// Constants, encodings and register map of the option loader and trim access block
`default_nettype none
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package opt_loader_pkg;

	//--------------------------------------------------------------------------
	// Flash locations
	//--------------------------------------------------------------------------
	localparam logic [15:0] OPT0_FLASH_ADDR = 16'h0000;
	localparam logic [15:0] OPT1_FLASH_ADDR = 16'h0001;
	localparam logic [15:0] TRIM_INFO_BASE = 16'h0020;
	localparam int TRIM_COUNT_DEF = 32;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [15:0] INFO_MAP_BASE = 16'hFE00;
	localparam logic [15:0] INFO_MAP_MASK = 16'hFE00;
	localparam int INFO_OFFSET_W = 9;

	//--------------------------------------------------------------------------
	// Option byte zero field positions
	//--------------------------------------------------------------------------
	localparam int BIT_WATCHDOG_ACTION = 7;
	localparam int BIT_WATCHDOG_ON = 6;
	localparam int BIT_BROWNOUT_ON = 3;
	localparam int BIT_READ_PROTECT = 2;
	localparam int BIT_WRITE_PROTECT = 0;

	//--------------------------------------------------------------------------
	// Trim indices
	//--------------------------------------------------------------------------
	localparam logic [7:0] TRIM_OSC_INDEX = 8'h02;

	//--------------------------------------------------------------------------
	// Register map: printed indices, byte address is four times the index
	//--------------------------------------------------------------------------
	localparam logic [15:0] IDX_LOAD_STATUS = 16'h0FF5;
	localparam logic [15:0] IDX_TRIM_INDEX = 16'h0FF6;
	localparam logic [15:0] IDX_TRIM_VALUE = 16'h0FF7;
	localparam logic [15:0] ADDR_LOAD_STATUS = IDX_LOAD_STATUS << 2;
	localparam logic [15:0] ADDR_TRIM_INDEX = IDX_TRIM_INDEX << 2;
	localparam logic [15:0] ADDR_TRIM_VALUE = IDX_TRIM_VALUE << 2;
	localparam logic [7:0] TRIM_INDEX_RESET = 8'h00;
	localparam int STAT_TRIM_LOADED = 0;
	localparam int STAT_LOADING = 1;

	//--------------------------------------------------------------------------
	// Loader states
	//--------------------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_LOAD_OPT0 = 4'b0001,
		ST_LOAD_OPT1 = 4'b0010,
		ST_LOAD_TRIM = 4'b0100,
		ST_RUN = 4'b1000
	} load_state_t;

endpackage : opt_loader_pkg
`default_nettype wire

// File: rtl/flash_byte_fetch.sv
// Single-byte flash read handshake used by the option loader
`timescale 1ns/100ps
`default_nettype none
module flash_byte_fetch
(
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic start_info,
	input wire logic [15:0] start_addr,
	output logic flash_req,
	output logic flash_info,
	output logic [15:0] flash_addr,
	input wire logic flash_valid,
	input wire logic [7:0] flash_rdata,
	output logic busy,
	output logic done,
	output logic [7:0] data
);
	logic req_q;
	logic req_d;
	logic info_q;
	logic info_d;
	logic [15:0] addr_q;
	logic [15:0] addr_d;

	// Request stays up until the flash answers; a new start is taken only when idle
	always_comb
	begin
		req_d = req_q;
		info_d = info_q;
		addr_d = addr_q;
		if (req_q && flash_valid)
		begin
			req_d = 1'b0;
		end
		else if (!req_q && start)
		begin
			req_d = 1'b1;
			info_d = start_info;
			addr_d = start_addr;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			req_q <= 1'b0;
			info_q <= 1'b0;
			addr_q <= 16'h0000;
		end
		else
		begin
			req_q <= req_d;
			info_q <= info_d;
			addr_q <= addr_d;
		end
	end

	assign flash_req = req_q;
	assign flash_info = info_q;
	assign flash_addr = addr_q;
	assign busy = req_q;
	assign done = req_q && flash_valid;
	assign data = flash_rdata;
endmodule : flash_byte_fetch
`default_nettype wire

// File: rtl/option_bit_loader_trim_access.sv
// Option byte loader, hidden option registers and trim working-copy access over APB
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module option_bit_loader_trim_access
#(
	parameter int TRIM_COUNT = opt_loader_pkg::TRIM_COUNT_DEF
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic power_on_rst,
	input wire logic stop_recovery,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic flash_req,
	output logic flash_info,
	output logic [15:0] flash_addr,
	input wire logic flash_valid,
	input wire logic [7:0] flash_rdata,
	input wire logic info_area_select,
	input wire logic [15:0] cpu_addr,
	output logic info_page_hit,
	output logic [opt_loader_pkg::INFO_OFFSET_W-1:0] info_page_offset,
	output logic cpu_hold,
	output logic watchdog_timeout_action,
	output logic watchdog_always_on,
	output logic brownout_always_on,
	output logic code_read_protect,
	output logic code_write_protect,
	output logic [7:0] oscillator_trim,
	output logic [7:0] reserved_options
);
	import opt_loader_pkg::*;

	localparam int IDX_W = $clog2(TRIM_COUNT);
	localparam logic [7:0] TRIM_LIMIT = 8'(TRIM_COUNT);
	localparam logic [IDX_W-1:0] TRIM_LAST = IDX_W'(TRIM_COUNT - 1);

	//--------------------------------------------------------------------------
	// Loader
	//--------------------------------------------------------------------------
	load_state_t state_q;
	load_state_t state_d;
	logic [IDX_W-1:0] cnt_q;
	logic [IDX_W-1:0] cnt_d;
	logic [7:0] opt0_q;
	logic [7:0] opt0_d;
	logic [7:0] opt1_q;
	logic [7:0] opt1_d;
	logic hold_q;
	logic hold_d;
	logic trim_loaded_q;
	logic trim_loaded_d;
	logic fetch_start;
	logic fetch_sel_info;
	logic [15:0] fetch_addr;
	logic fetch_busy;
	logic fetch_done;
	logic [7:0] fetch_data;
	logic fetch_abort;
	logic load_we;

	// Stop recovery aborts any fetch under way and restarts the load from byte zero
	assign fetch_abort = rst || stop_recovery;

	flash_byte_fetch u_fetch
	(
		.clk(clk),
		.rst(fetch_abort),
		.start(fetch_start),
		.start_info(fetch_sel_info),
		.start_addr(fetch_addr),
		.flash_req(flash_req),
		.flash_info(flash_info),
		.flash_addr(flash_addr),
		.flash_valid(flash_valid),
		.flash_rdata(flash_rdata),
		.busy(fetch_busy),
		.done(fetch_done),
		.data(fetch_data)
	);

	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		opt0_d = opt0_q;
		opt1_d = opt1_q;
		hold_d = 1'b1;
		trim_loaded_d = trim_loaded_q;
		fetch_start = 1'b0;
		fetch_sel_info = 1'b0;
		fetch_addr = OPT0_FLASH_ADDR;
		load_we = 1'b0;
		case (state_q)
			ST_LOAD_OPT0:
			begin
				fetch_start = !fetch_busy;
				fetch_addr = OPT0_FLASH_ADDR;
				if (fetch_done)
				begin
					opt0_d = fetch_data;
					state_d = ST_LOAD_OPT1;
				end
			end
			ST_LOAD_OPT1:
			begin
				fetch_start = !fetch_busy;
				fetch_addr = OPT1_FLASH_ADDR;
				if (fetch_done)
				begin
					opt1_d = fetch_data;
					// Working trim copies survive resets; only power-on refetches them
					if (trim_loaded_q)
					begin
						state_d = ST_RUN;
						hold_d = 1'b0;
					end
					else
					begin
						state_d = ST_LOAD_TRIM;
					end
				end
			end
			ST_LOAD_TRIM:
			begin
				fetch_start = !fetch_busy;
				fetch_sel_info = 1'b1;
				fetch_addr = TRIM_INFO_BASE + 16'(cnt_q);
				if (fetch_done)
				begin
					load_we = 1'b1;
					cnt_d = cnt_q + 1'b1;
					if (cnt_q == TRIM_LAST)
					begin
						trim_loaded_d = 1'b1;
						state_d = ST_RUN;
						hold_d = 1'b0;
					end
				end
			end
			ST_RUN:
			begin
				hold_d = 1'b0;
			end
			default:
			begin
				state_d = ST_LOAD_OPT0;
			end
		endcase
		if (fetch_abort)
		begin
			// Options change only at rst and on a later reload, never while running
			state_d = ST_LOAD_OPT0;
			cnt_d = '0;
			hold_d = 1'b1;
			fetch_start = 1'b0;
			load_we = 1'b0;
		end
		if (rst)
		begin
			opt0_d = ERASED_BYTE;
			opt1_d = ERASED_BYTE;
		end
		if (power_on_rst)
		begin
			trim_loaded_d = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		state_q <= state_d;
		cnt_q <= cnt_d;
		opt0_q <= opt0_d;
		opt1_q <= opt1_d;
		hold_q <= hold_d;
		trim_loaded_q <= trim_loaded_d;
	end

	//--------------------------------------------------------------------------
	// Trim working copies and APB slave
	//--------------------------------------------------------------------------
	// Option registers are deliberately absent from this decode
	logic [7:0] trim_mem_q [TRIM_COUNT];
	logic mem_we;
	logic [IDX_W-1:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic [7:0] trim_index_q;
	logic [7:0] trim_index_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;
	logic apb_setup;
	logic apb_access;
	logic trim_in_range;

	assign apb_setup = psel && !penable;
	assign apb_access = psel && penable && pready_q;
	assign trim_in_range = trim_index_q < TRIM_LIMIT;

	always_comb
	begin
		trim_index_d = trim_index_q;
		prdata_d = 32'h0000_0000;
		pready_d = apb_setup;
		pslverr_d = 1'b0;
		mem_we = load_we;
		mem_waddr = cnt_q;
		mem_wdata = fetch_data;
		if (apb_setup)
		begin
			if (paddr == ADDR_TRIM_INDEX)
			begin
				prdata_d = {24'h00_0000, trim_index_q};
			end
			else if (paddr == ADDR_TRIM_VALUE)
			begin
				if (trim_in_range)
				begin
					prdata_d = {24'h00_0000, trim_mem_q[trim_index_q[IDX_W-1:0]]};
				end
			end
			else if (paddr == ADDR_LOAD_STATUS)
			begin
				prdata_d[STAT_TRIM_LOADED] = trim_loaded_q;
				prdata_d[STAT_LOADING] = hold_q;
			end
			else
			begin
				pslverr_d = 1'b1;
			end
		end
		if (apb_access && pwrite && !load_we)
		begin
			if (paddr == ADDR_TRIM_INDEX)
			begin
				trim_index_d = pwdata[7:0];
			end
			else if (paddr == ADDR_TRIM_VALUE && trim_in_range)
			begin
				mem_we = 1'b1;
				mem_waddr = trim_index_q[IDX_W-1:0];
				mem_wdata = pwdata[7:0];
			end
		end
		if (rst)
		begin
			trim_index_d = TRIM_INDEX_RESET;
			pready_d = 1'b0;
			pslverr_d = 1'b0;
			mem_we = 1'b0;
		end
	end

	// No reset on the copies: they must stay as they are through system resets
	always_ff @(posedge clk)
	begin
		if (mem_we)
		begin
			trim_mem_q[mem_waddr] <= mem_wdata;
		end
	end

	always_ff @(posedge clk)
	begin
		trim_index_q <= trim_index_d;
		prdata_q <= prdata_d;
		pready_q <= pready_d;
		pslverr_q <= pslverr_d;
	end

	//--------------------------------------------------------------------------
	// Information page window
	//--------------------------------------------------------------------------
	logic info_hit_q;
	logic info_hit_d;
	logic [INFO_OFFSET_W-1:0] info_off_q;
	logic [INFO_OFFSET_W-1:0] info_off_d;

	always_comb
	begin
		info_hit_d = info_area_select && ((cpu_addr & INFO_MAP_MASK) == INFO_MAP_BASE);
		info_off_d = cpu_addr[INFO_OFFSET_W-1:0];
		if (rst)
		begin
			info_hit_d = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		info_hit_q <= info_hit_d;
		info_off_q <= info_off_d;
	end

	//--------------------------------------------------------------------------
	// Outputs
	//--------------------------------------------------------------------------
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign info_page_hit = info_hit_q;
	assign info_page_offset = info_off_q;
	assign cpu_hold = hold_q;
	assign watchdog_timeout_action = opt0_q[BIT_WATCHDOG_ACTION];
	assign watchdog_always_on = opt0_q[BIT_WATCHDOG_ON];
	assign brownout_always_on = opt0_q[BIT_BROWNOUT_ON];
	assign code_read_protect = opt0_q[BIT_READ_PROTECT];
	assign code_write_protect = opt0_q[BIT_WRITE_PROTECT];
	assign oscillator_trim = trim_mem_q[TRIM_OSC_INDEX[IDX_W-1:0]];
	// Reserved byte is stored but steers nothing
	assign reserved_options = opt1_q;

	//--------------------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------------------
	property p_hold_until_loaded;
		@(posedge clk) disable iff (rst)
		(state_q != ST_RUN) |-> cpu_hold;
	endproperty
	a_hold_until_loaded: assert property (p_hold_until_loaded)
		else $error("processor released before options loaded");

	property p_reset_restarts_load;
		@(posedge clk) (rst || stop_recovery) |=> (state_q == ST_LOAD_OPT0) && cpu_hold && !flash_req;
	endproperty
	a_reset_restarts_load: assert property (p_reset_restarts_load)
		else $error("reset did not restart the option load");

	property p_options_stable_running;
		@(posedge clk) disable iff (rst)
		(!cpu_hold && !$past(cpu_hold)) |-> $stable(opt0_q) && $stable(opt1_q);
	endproperty
	a_options_stable_running: assert property (p_options_stable_running)
		else $error("option registers changed while running");

	property p_option_fetch_addr;
		@(posedge clk) disable iff (rst)
		(flash_req && state_q == ST_LOAD_OPT1) |-> !flash_info && flash_addr == OPT1_FLASH_ADDR;
	endproperty
	a_option_fetch_addr: assert property (p_option_fetch_addr)
		else $error("option byte one fetched from wrong place");

	property p_options_follow_flash;
		@(posedge clk) disable iff (rst || stop_recovery)
		(state_q == ST_LOAD_OPT0 && fetch_done) |=>
			watchdog_timeout_action == $past(flash_rdata[BIT_WATCHDOG_ACTION])
			&& code_write_protect == $past(flash_rdata[BIT_WRITE_PROTECT]);
	endproperty
	a_options_follow_flash: assert property (p_options_follow_flash)
		else $error("option outputs do not follow fetched byte");

	property p_erased_at_reset;
		@(posedge clk) rst |=> watchdog_timeout_action && watchdog_always_on
			&& brownout_always_on && code_read_protect && code_write_protect;
	endproperty
	a_erased_at_reset: assert property (p_erased_at_reset)
		else $error("options not erased defaults at reset");

	property p_trim_fetch_range;
		@(posedge clk) disable iff (rst)
		(flash_req && flash_info) |-> flash_addr >= TRIM_INFO_BASE
			&& flash_addr < TRIM_INFO_BASE + 16'(TRIM_COUNT);
	endproperty
	a_trim_fetch_range: assert property (p_trim_fetch_range)
		else $error("info fetch outside trim range");

	property p_out_of_range_reads_zero;
		@(posedge clk) disable iff (rst)
		(apb_setup && paddr == ADDR_TRIM_VALUE && !trim_in_range) |=> pready && prdata == 32'h0;
	endproperty
	a_out_of_range_reads_zero: assert property (p_out_of_range_reads_zero)
		else $error("out of range trim read not zero");

	property p_trim_write_lands;
		@(posedge clk) disable iff (rst)
		(apb_access && pwrite && paddr == ADDR_TRIM_VALUE && trim_in_range && !load_we) |=>
			trim_mem_q[$past(trim_index_q[IDX_W-1:0])] == $past(pwdata[7:0]);
	endproperty
	a_trim_write_lands: assert property (p_trim_write_lands)
		else $error("trim write not stored");

	property p_trim_kept_over_reset;
		@(posedge clk) (rst && !power_on_rst && trim_loaded_q) |=> $stable(oscillator_trim);
	endproperty
	a_trim_kept_over_reset: assert property (p_trim_kept_over_reset)
		else $error("oscillator trim changed by reset");

	property p_unmapped_error;
		@(posedge clk) disable iff (rst)
		(apb_setup && paddr == OPT0_FLASH_ADDR) |=> pready && pslverr;
	endproperty
	a_unmapped_error: assert property (p_unmapped_error)
		else $error("option byte address answered without error");

	property p_info_window;
		@(posedge clk) disable iff (rst)
		(info_area_select && cpu_addr[15:9] == INFO_MAP_BASE[15:9]) |=> info_page_hit;
	endproperty
	a_info_window: assert property (p_info_window)
		else $error("info page window not mapped");

	c_trim_loaded: cover property (@(posedge clk) disable iff (rst) $rose(trim_loaded_q));
	c_stop_reload: cover property (@(posedge clk) disable iff (rst) stop_recovery ##1 cpu_hold);
	c_trim_write: cover property (@(posedge clk) disable iff (rst)
		apb_access && pwrite && paddr == ADDR_TRIM_VALUE);
	c_slave_error: cover property (@(posedge clk) disable iff (rst) pready && pslverr);
endmodule : option_bit_loader_trim_access
`default_nettype wire

// File: test/tb_option_bit_loader_trim_access.sv
// Self-checking testbench for the option loader and trim access block
`timescale 1ns/100ps
`default_nettype none
module tb_option_bit_loader_trim_access;
	import opt_loader_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic power_on_rst = 1'b1;
	logic stop_recovery = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0;
	logic flash_valid = 1'b0;
	logic [7:0] flash_rdata = 8'h00;
	logic info_area_select = 1'b0;
	logic [15:0] cpu_addr = 16'h0000;
	logic [31:0] prdata;
	logic pready, pslverr, flash_req, flash_info, info_page_hit, cpu_hold;
	logic [15:0] flash_addr;
	logic [INFO_OFFSET_W-1:0] info_page_offset;
	logic wd_action, wd_on, bo_on, rd_prot, wr_prot;
	logic [7:0] oscillator_trim, reserved_options;
	logic [4:0] opt_seen;
	logic [7:0] prog [2];
	logic [7:0] info [32];
	logic [7:0] work [32];
	int errors = 0;
	int n_checks = 0;
	int n_served = 0;
	int cycles = 0;

	option_bit_loader_trim_access #(.TRIM_COUNT(32)) dut (.clk(clk), .rst(rst),
		.power_on_rst(power_on_rst), .stop_recovery(stop_recovery), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .flash_req(flash_req), .flash_info(flash_info),
		.flash_addr(flash_addr), .flash_valid(flash_valid), .flash_rdata(flash_rdata),
		.info_area_select(info_area_select), .cpu_addr(cpu_addr),
		.info_page_hit(info_page_hit), .info_page_offset(info_page_offset),
		.cpu_hold(cpu_hold), .watchdog_timeout_action(wd_action), .watchdog_always_on(wd_on),
		.brownout_always_on(bo_on), .code_read_protect(rd_prot),
		.code_write_protect(wr_prot), .oscillator_trim(oscillator_trim),
		.reserved_options(reserved_options));

	assign opt_seen = {wd_action, wd_on, bo_on, rd_prot, wr_prot};

	always #12.5 clk = ~clk;

	//--------------------------------------------------------------------------
	// Checking and reporting
	//--------------------------------------------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	function automatic logic [4:0] exp_opt(input logic [7:0] b);
		return {b[BIT_WATCHDOG_ACTION], b[BIT_WATCHDOG_ON], b[BIT_BROWNOUT_ON],
			b[BIT_READ_PROTECT], b[BIT_WRITE_PROTECT]};
	endfunction : exp_opt

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			errors++;
			results();
		end
	end

	//--------------------------------------------------------------------------
	// Flash array: answers after a random stall, scrambles data when idle
	//--------------------------------------------------------------------------
	always @(posedge clk)
	begin
		if (flash_req && flash_valid)
			n_served <= n_served + 1;
		if (flash_req && !flash_valid && $urandom_range(0, 2) == 0)
		begin
			chk("flash address", flash_info ? flash_addr[15:5] == 11'h001 : flash_addr[15:1] == 0, 1);
			flash_valid <= 1'b1;
			flash_rdata <= flash_info ? info[flash_addr[4:0]] : prog[flash_addr[0]];
		end
		else
		begin
			flash_valid <= 1'b0;
			flash_rdata <= ~flash_rdata;
		end
	end

	//--------------------------------------------------------------------------
	// Reset, load and bus helpers
	//--------------------------------------------------------------------------
	// Only the global cycle ceiling ends a load that never finishes
	task automatic wait_load();
		while (cpu_hold !== 1'b0)
		begin
			@(posedge clk);
		end
	endtask : wait_load

	task automatic do_reset(input logic por);
		int n0;
		n0 = n_served;
		rst <= 1'b1;
		power_on_rst <= por;
		repeat (6) @(posedge clk);
		chk("hold in reset", cpu_hold, 1);
		chk("options in reset", {opt_seen, reserved_options}, 13'h1FFF);
		rst <= 1'b0;
		power_on_rst <= 1'b0;
		@(posedge clk);
		wait_load();
		chk("bytes before release", n_served - n0, por ? 34 : 2);
		chk("option bits", opt_seen, exp_opt(prog[0]));
		chk("option byte one", reserved_options, prog[1]);
		chk("oscillator trim", oscillator_trim, work[2]);
	endtask : do_reset

	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
		input logic [31:0] exp, input logic experr);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1);
		chk("access cycles", k, 1);
		chk("pslverr", pslverr, experr);
		if (!w)
			chk("read data", prdata, exp);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : acc

	task automatic read_all();
		for (int i = 0; i < 32; i++)
		begin
			acc(1, ADDR_TRIM_INDEX, i[7:0], 0, 0);
			acc(0, ADDR_TRIM_VALUE, 0, {24'h0, work[i]}, 0);
		end
	endtask : read_all

	task automatic tdone(input string nm);
		$display("test %s done", nm);
	endtask : tdone

	//--------------------------------------------------------------------------
	// Main sequence
	//--------------------------------------------------------------------------
	initial
	begin
		logic [7:0] old;
		logic [7:0] d;
		int i;
		void'($urandom(32'hfa8b));
		foreach (info[j])
			info[j] = $urandom_range(0, 255);
		work = info;
		prog[0] = $urandom_range(0, 255) | 8'h32;
		prog[1] = 8'hFF;
		do_reset(1);
		acc(0, ADDR_TRIM_INDEX, 0, 32'h0, 0);
		acc(0, ADDR_LOAD_STATUS, 0, 32'h1, 0);
		read_all();
		tdone("power-on load");
		for (int j = 0; j < 20; j++)
		begin
			i = (j == 0) ? 31 : (j == 1) ? 2 : $urandom_range(0, 31);
			d = $urandom_range(0, 255);
			work[i] = d;
			acc(1, ADDR_TRIM_INDEX, i[7:0], 0, 0);
			acc(1, ADDR_TRIM_VALUE, d, 0, 0);
			acc(0, ADDR_TRIM_VALUE, 0, {24'h0, d}, 0);
		end
		chk("oscillator trim", oscillator_trim, work[2]);
		tdone("trim write");
		acc(1, ADDR_TRIM_INDEX, 8'h20, 0, 0);
		acc(1, ADDR_TRIM_VALUE, 8'h5A, 0, 0);
		acc(0, ADDR_TRIM_VALUE, 0, 32'h0, 0);
		acc(0, ADDR_TRIM_INDEX, 0, 32'h20, 0);
		acc(0, 16'h0000, 0, 32'h0, 1);
		acc(1, ADDR_TRIM_VALUE + 16'h0004, 8'h00, 0, 1);
		read_all();
		tdone("register access");
		old = prog[0];
		prog[0] = $urandom_range(0, 255) | 8'h32;
		repeat (5) @(posedge clk);
		chk("options before reload", opt_seen, exp_opt(old));
		do_reset(0);
		read_all();
		tdone("system reset reload");
		prog[0] = ~prog[0] | 8'h32;
		i = n_served;
		stop_recovery <= 1'b1;
		@(posedge clk);
		stop_recovery <= 1'b0;
		while (n_served - i < 2)
			@(posedge clk);
		@(posedge clk);
		wait_load();
		chk("option bits", opt_seen, exp_opt(prog[0]));
		tdone("stop recovery");
		prog[0] = ERASED_BYTE;
		prog[1] = ERASED_BYTE;
		do_reset(0);
		work = info;
		do_reset(1);
		read_all();
		tdone("erase and power loss");
		for (int j = 0; j < 40; j++)
		begin
			info_area_select <= $urandom_range(0, 1);
			cpu_addr <= {($urandom_range(0, 1) ? 7'h7F : 7'($urandom_range(0, 127))), 9'($urandom)};
			@(posedge clk);
			@(posedge clk);
			chk("info hit", info_page_hit, info_area_select && cpu_addr[15:9] == 7'h7F);
			chk("info offset", info_page_offset, cpu_addr[8:0]);
		end
		tdone("info window");
		results();
	end
endmodule : tb_option_bit_loader_trim_access
`default_nettype wire
